//--- pwpg_consts.vh
/*
  Constants for the peripheral write-protect block, group two:
  register offsets, field positions, reset values and bus widths.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PWPG_CONSTS_VH
`define PWPG_CONSTS_VH

// ============================================================
// Bus widths
`define PWPG_DATA_W        32
`define PWPG_ADDR_W        8
`define PWPG_SEL_W         4
`define PWPG_NFLAG         20
`define PWPG_IDX_W         5

// ============================================================
// Register offsets (byte addresses)
`define PWPG_OFF_CLEAR     8'h00
`define PWPG_OFF_SET       8'h04
`define PWPG_OFF_STATUS    8'h08

// ============================================================
// Reset values and masks
`define PWPG_RESET_VAL     32'h00800000
`define PWPG_FLAG_MASK     32'h000ffffe
`define PWPG_ZERO32        32'h00000000
`define PWPG_FLAG_RESET    1'h0

// ============================================================
// Flag positions in both protect registers
`define PWPG_FLAG_LO       1
`define PWPG_FLAG_HI       19
`define PWPG_BIT_EVENT     1
`define PWPG_BIT_SERIAL0   2
`define PWPG_BIT_SERIAL5   7
`define PWPG_BIT_TIMER0    8
`define PWPG_BIT_TIMER7    15
`define PWPG_BIT_ADC       16
`define PWPG_BIT_AC        17
`define PWPG_BIT_DAC       18
`define PWPG_BIT_TOUCH     19

// ============================================================
// Status register fields
`define PWPG_ST_BLK_BIT    0
`define PWPG_ST_IDX_LSB    8
`define PWPG_ST_IDX_MSB    12
`define PWPG_IDX_RESET     5'h00

`endif

//--- pwpg_gate.v
/*
  Write gate for the protected peripherals: passes or blocks one
  peripheral-bus write according to the protection flags.
  Assumes a one-hot target select and flags from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pwpg_consts.vh"

module pwpg_gate (
  // Protection state
  input  wire [`PWPG_NFLAG-1:0] i_flags,
  // Peripheral write request
  input  wire [`PWPG_NFLAG-1:0] i_target_sel,
  input  wire                   i_target_wr,
  // Gate result
  output wire                   o_wr_allow,
  output wire                   o_wr_blocked,
  output reg  [`PWPG_IDX_W-1:0] o_blocked_idx
);

  // ============================================================
  // Gating
  wire [`PWPG_NFLAG-1:0] hit;
  integer                k;

  // Protected target under a write
  assign hit          = i_target_sel & i_flags;
  assign o_wr_blocked = i_target_wr & (|hit);
  assign o_wr_allow   = i_target_wr & ~(|hit);

  // Index of the lowest blocked target
  always @* begin
    o_blocked_idx = `PWPG_IDX_RESET;
    for (k = `PWPG_FLAG_HI; k >= `PWPG_FLAG_LO; k = k - 1) begin
      if (hit[k]) begin
        o_blocked_idx = k[`PWPG_IDX_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- pwpg_ctrl.v
/*
  Peripheral write-protect controller, group two. Holds one protection
  flag per peripheral (event system, six serial units, eight timers,
  converter, comparator, DAC, touch), reached by software through a
  clear register and a set register over classic Wishbone, and gates
  writes on the peripheral bus toward protected peripherals.
  Assumes one clock, i_mclk at 10 MHz, and an asynchronous active-low
  reset; peripheral-bus inputs come from logic on the same clock.
*/
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pwpg_consts.vh"

module pwpg_ctrl (
  // Clock and reset
  input  wire                    i_mclk,
  input  wire                    i_reset_n,
  // Wishbone slave
  input  wire                    i_wb_cyc,
  input  wire                    i_wb_stb,
  input  wire                    i_wb_we,
  input  wire [`PWPG_ADDR_W-1:0] i_wb_adr,
  input  wire [`PWPG_SEL_W-1:0]  i_wb_sel,
  input  wire [`PWPG_DATA_W-1:0] i_wb_dat,
  output reg  [`PWPG_DATA_W-1:0] o_wb_dat,
  output reg                     o_wb_ack,
  // Peripheral-bus write gating
  input  wire [`PWPG_NFLAG-1:0]  i_periph_sel,
  input  wire                    i_periph_wr,
  output wire                    o_periph_wr_allow,
  output wire                    o_periph_wr_blocked,
  // Protection state
  output wire [`PWPG_NFLAG-1:0]  o_protect_flags
);

  // ============================================================
  // Decoding helpers

  // Byte-lane enables widened to a word mask
  function [`PWPG_DATA_W-1:0] lane_mask;
    input [`PWPG_SEL_W-1:0] sel;
    integer                 b;
    begin
      lane_mask = `PWPG_ZERO32;
      for (b = 0; b < `PWPG_SEL_W; b = b + 1) begin
        if (sel[b]) begin
          lane_mask[b*8 +: 8] = 8'hff;
        end
      end
    end
  endfunction

  // Address match for one register offset
  function addr_is;
    input [`PWPG_ADDR_W-1:0] adr;
    input [`PWPG_ADDR_W-1:0] off;
    begin
      addr_is = (adr == off);
    end
  endfunction

  // ============================================================
  // Bus request

  wire                    req;
  wire                    req_wr;
  wire                    req_rd;
  wire [`PWPG_DATA_W-1:0] wdata;
  wire                    hit_clear;
  wire                    hit_set;
  wire                    hit_status;

  // New request only while no answer is pending
  assign req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign req_wr = req & i_wb_we;
  assign req_rd = req & ~i_wb_we;

  // Write data with disabled byte lanes forced to zero
  assign wdata = i_wb_dat & lane_mask(i_wb_sel);

  // Register decode
  assign hit_clear  = addr_is(i_wb_adr, `PWPG_OFF_CLEAR);
  assign hit_set    = addr_is(i_wb_adr, `PWPG_OFF_SET);
  assign hit_status = addr_is(i_wb_adr, `PWPG_OFF_STATUS);

  // ============================================================
  // Bit-wise strobes

  wire [`PWPG_DATA_W-1:0] clr_bits;
  wire [`PWPG_DATA_W-1:0] set_bits;

  // Only ones written reach a flag; zeros leave it alone
  assign clr_bits = (req_wr & hit_clear) ? (wdata & `PWPG_FLAG_MASK)
                                         : `PWPG_ZERO32;
  assign set_bits = (req_wr & hit_set) ? (wdata & `PWPG_FLAG_MASK)
                                       : `PWPG_ZERO32;

  // ============================================================
  // Protection flags

  wire [`PWPG_NFLAG-1:0] flags;

  // Bit 0 holds no peripheral
  assign flags[0] = `PWPG_FLAG_RESET;

  genvar g;
  generate
    for (g = `PWPG_FLAG_LO; g <= `PWPG_FLAG_HI; g = g + 1) begin : g_flag
      reg  flag_q;
      wire next_flag;

      // Set by a one in the set register, dropped by a one in clear
      assign next_flag = (flag_q & ~clr_bits[g]) | set_bits[g];

      // Flag storage
      always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          flag_q <= `PWPG_FLAG_RESET;
        end else begin
          flag_q <= next_flag;
        end
      end

      assign flags[g] = flag_q;
    end
  endgenerate

  assign o_protect_flags = flags;

  // ============================================================
  // Peripheral write gate

  wire                   gate_blocked;
  wire [`PWPG_IDX_W-1:0] gate_idx;

  pwpg_gate u_gate (
    .i_flags       (flags),
    .i_target_sel  (i_periph_sel),
    .i_target_wr   (i_periph_wr),
    .o_wr_allow    (o_periph_wr_allow),
    .o_wr_blocked  (gate_blocked),
    .o_blocked_idx (gate_idx)
  );

  assign o_periph_wr_blocked = gate_blocked;

  // ============================================================
  // Blocked-write status

  reg                   blocked;
  reg [`PWPG_IDX_W-1:0] blocked_idx;
  wire                  blocked_clr;
  wire                  next_blocked;

  // Software clears by writing one to the status flag bit
  assign blocked_clr  = req_wr & hit_status & wdata[`PWPG_ST_BLK_BIT];
  // A new block in the clearing cycle wins over the clear
  assign next_blocked = gate_blocked | (blocked & ~blocked_clr);

  // Sticky flag and index of the last blocked target
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      blocked     <= 1'h0;
      blocked_idx <= `PWPG_IDX_RESET;
    end else begin
      blocked <= next_blocked;
      if (gate_blocked) begin
        blocked_idx <= gate_idx;
      end
    end
  end

  // ============================================================
  // Read-back

  reg  [`PWPG_DATA_W-1:0] read_word;
  wire [`PWPG_DATA_W-1:0] flag_word;

  // Flags in place; reserved bits show the reset pattern
  assign flag_word = (`PWPG_RESET_VAL & ~`PWPG_FLAG_MASK)
                   | ({{(`PWPG_DATA_W-`PWPG_NFLAG){1'b0}}, flags}
                      & `PWPG_FLAG_MASK);

  // Word selected by address; unmapped reads as zero
  always @* begin
    read_word = `PWPG_ZERO32;
    if (hit_clear | hit_set) begin
      read_word = flag_word;
    end else if (hit_status) begin
      read_word[`PWPG_ST_BLK_BIT] = blocked;
      read_word[`PWPG_ST_IDX_MSB:`PWPG_ST_IDX_LSB] = blocked_idx;
    end
  end

  // ============================================================
  // Bus answer

  // One-cycle acknowledge, data registered with it
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'h0;
      o_wb_dat <= `PWPG_ZERO32;
    end else begin
      o_wb_ack <= req;
      if (req_rd) begin
        o_wb_dat <= read_word;
      end
    end
  end

endmodule
`default_nettype wire

//--- pwpg_checker.sv
/*
  Checker for the write-protect block: bus answer timing, flag
  updates, read-back and write gating.
  Assumes binding to pwpg_ctrl, one clock, active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pwpg_consts.vh"
// ============================================================
// Checker module
module pwpg_checker (
  input wire logic                    i_mclk,
  input wire logic                    i_reset_n,
  input wire logic                    i_wb_cyc,
  input wire logic                    i_wb_stb,
  input wire logic                    i_wb_we,
  input wire logic [`PWPG_ADDR_W-1:0] i_wb_adr,
  input wire logic [`PWPG_SEL_W-1:0]  i_wb_sel,
  input wire logic [`PWPG_DATA_W-1:0] i_wb_dat,
  input wire logic [`PWPG_DATA_W-1:0] o_wb_dat,
  input wire logic                    o_wb_ack,
  input wire logic [`PWPG_NFLAG-1:0]  i_periph_sel,
  input wire logic                    i_periph_wr,
  input wire logic                    o_periph_wr_allow,
  input wire logic                    o_periph_wr_blocked,
  input wire logic [`PWPG_NFLAG-1:0]  o_protect_flags
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Request taken, and full-word write to one offset
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_wr(logic [7:0] off);
    s_take ##0 i_wb_we && i_wb_sel == 4'hf && i_wb_adr == off;
  endsequence
  a_ack_one_pulse: assert property (s_take |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single pulse one cycle after request");
  a_clear_drops: assert property (s_wr(8'h00) |=> (o_protect_flags & $past(i_wb_dat[19:0])) == 0)
    else $error("flag still set after clear write");
  a_clear_keeps: assert property (s_wr(8'h00) |=> ((o_protect_flags ^ $past(o_protect_flags))
    & ~$past(i_wb_dat[19:0])) == 0) else $error("flag changed by zero bit");
  a_set_raises: assert property (s_wr(8'h04) |=> (o_protect_flags & $past(i_wb_dat[19:0]))
    == ($past(i_wb_dat[19:0]) & 20'hffffe)) else $error("flag not set");
  a_read_flags: assert property (s_take ##0 !i_wb_we && i_wb_adr[7:3] == 0 && !i_wb_adr[1:0]
    |=> o_wb_dat == (({12'h000, o_protect_flags} & `PWPG_FLAG_MASK) | `PWPG_RESET_VAL))
    else $error("read data differs from flags");
  a_gate_split: assert property (i_periph_wr |-> o_periph_wr_blocked ==
    |(i_periph_sel & o_protect_flags) && o_periph_wr_allow == !o_periph_wr_blocked)
    else $error("peripheral write gating wrong");
endmodule
bind pwpg_ctrl pwpg_checker u_chk (.i_mclk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_periph_sel, .i_periph_wr,
  .o_periph_wr_allow, .o_periph_wr_blocked, .o_protect_flags);
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the write-protect block: register access
  over classic Wishbone and peripheral write gating.
  Assumes pwpg_ctrl and its constants header on the compile path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pwpg_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// ============================================================
// Top module
module tb;
  logic i_mclk = 0, i_reset_n = 0, cyc = 0, stb = 0, we = 0, pwr = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rdat, q, exp;
  logic [19:0] psel = 0;
  logic ack, allow, blk;
  logic [19:0] flags;
  int n_mismatch = 0, check_count = 0, cycles = 0;
  pwpg_ctrl u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_periph_sel(psel), .i_periph_wr(pwr), .o_periph_wr_allow(allow),
    .o_periph_wr_blocked(blk), .o_protect_flags(flags));
  // 10 MHz clock and hang limit
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge i_mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1;
    wb(8'h00, 0, 0); `CHK(q, 32'h00800000)
    wb(8'h04, 0, 0); `CHK(q, 32'h00800000)
    $display("test reset values done");
    exp = 32'h008ffffe;
    wb(8'h04, 1, 32'hffffffff);
    wb(8'h04, 0, 0); `CHK(q, exp)
    wb(8'h00, 1, 0);
    wb(8'h00, 0, 0); `CHK(q, exp)
    wb(8'h10, 1, 32'hffffffff);
    `CHK(flags, 20'hffffe)
    wb(8'h0c, 0, 0); `CHK(q, 32'h0)
    $display("test set and zero clear done");
    for (int b = 1; b < 20; b++) begin
      @(posedge i_mclk);
      psel <= 20'h1 << b; pwr <= 1;
      @(posedge i_mclk); #1;
      `CHK(({allow, blk}), 2'b01)
      wb(8'h00, 1, 32'h1 << b);
      exp[b] = 0;
      wb(8'h04, 0, 0); `CHK(q, exp)
      #1;
      `CHK(({allow, blk}), 2'b10)
    end
    @(posedge i_mclk);
    pwr <= 0;
    $display("test per-flag clear and gating done");
    // Sticky blocked flag with index 19 of the last blocked target
    wb(8'h08, 0, 0); `CHK(q, 32'h00001301)
    wb(8'h08, 1, 32'h00000001);
    wb(8'h08, 0, 0); `CHK(q, 32'h00001300)
    $display("test blocked-write status done");
    // Reset in mid-run drops every flag
    wb(8'h04, 1, 32'hffffffff);
    i_reset_n <= 0;
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1;
    `CHK(flags, 20'h00000)
    wb(8'h04, 0, 0); `CHK(q, 32'h00800000)
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
